/* File: bpi_device.sv */
// The register addresses and the plain strobed port were decided locally.
`timescale 1ns/100ps
// Behaviour
// - Host sets interrupt enable bit 15 first
// - Interrupt when stack count drops two to one
// - Push command stacks patterns, clears interrupt
// - Command 3Dh clears interpolation interrupt
// - Drive stop clears interrupt, releases line
// - 36h enables, 37h disables, 39h clears
// - Command 34h starts two-axis pattern drive
// - Host waits while stack count reads three
// - Status bit 8 shows drive running
// - Host supplies four 16-bit words, pushed as one group
// - Each word holds 16 points, LSB first
// - Mode bits 9,8 = 0,1: two-axis CLV
// - One axis main range, both second range
// - Host loads second range at 1.414x
// - Mode bits 9,8 = 1,1: three-axis CLV
// - One/two/three axes pick main/second/third range
// - Two-axis CLV on three axes: first two
// - Stack count steers push into slots
// - Pulse on bit 0, advance after 16
// - Both first-axis bits set ends drive
// - All axes step on main basic pulse
module bpi_device
	import bpi_pkg::*;
(
	input  wire logic              ref_clk,
	input  wire logic              srst,
	bpi_if.device                  bus,
	input  wire logic              basicPulse,
	input  wire logic              stopReq,
	output logic [bpi_pkg::N_AXIS-1:0] plusPulse,
	output logic [bpi_pkg::N_AXIS-1:0] minusPulse,
	output logic [1:0]             rangeSel,
	output logic                   driveBusy
);
	import bpi_pkg::*;

	typedef logic [N_AXIS-1:0][1:0][W_DATA-1:0] bpi_pat_t;

	typedef struct packed {
		logic [1:0]        stackCnt;
		logic [3:0]        bitIdx;
		logic              busy;
		logic              three;
		logic              wrEn;
		logic              intPend;
		logic [W_DATA-1:0] mode;
		bpi_pat_t          hold;
		bpi_pat_t          shift;
		bpi_pat_t          q1;
		bpi_pat_t          q2;
		logic [N_AXIS-1:0] plusP;
		logic [N_AXIS-1:0] minusP;
		logic [1:0]        rangeSel;
		logic [W_DATA-1:0] rdata;
	} bpi_dev_s;

	bpi_dev_s r;
	bpi_dev_s next_r;

	// Count of stepping axes picks the range; only first two in mode 01.
	function automatic logic [1:0] clvRange(input logic [1:0] clv,
		input logic [N_AXIS-1:0] step);
		logic [1:0] cnt;
		cnt = 2'(step[0]) + 2'(step[1]) + 2'(step[2]);
		clvRange = RANGE_MAIN;
		if (clv == CLV_TWO && step[0] && step[1])
		begin
			clvRange = RANGE_SECOND;
		end
		else if (clv == CLV_THREE && cnt == 2'h2)
		begin
			clvRange = RANGE_SECOND;
		end
		else if (clv == CLV_THREE && cnt == 2'h3)
		begin
			clvRange = RANGE_THIRD;
		end
	endfunction

	always_comb
	begin
		logic              intSet;
		logic              intClr;
		logic              isCmd;
		logic [2:0]        off;
		logic [N_AXIS-1:0] active;
		intSet = 1'b0;
		intClr = 1'b0;
		isCmd = bus.busWr && bus.busAddr == ADDR_CMD;
		off = 3'(bus.busAddr - ADDR_PAT_FIRST);
		active = {r.three, 2'b11};
		next_r = r;
		next_r.plusP = '0;
		next_r.minusP = '0;
		next_r.rdata = '0;

		if (bus.busRd)
		begin
			case (bus.busAddr)
				ADDR_STATUS:
				begin
					next_r.rdata[STAT_CNT_HI:STAT_CNT_LO] = r.stackCnt;
					next_r.rdata[STAT_BUSY] = r.busy;
				end
				ADDR_MODE:
				begin
					next_r.rdata = r.mode;
				end
				default:
				begin
					next_r.rdata = '0;
				end
			endcase
		end

		// Every axis steps together on the main axis basic pulse, the third only after a 35h start.
		if (r.busy && basicPulse)
		begin
			if (r.shift[0][0][0] && r.shift[0][1][0])
			begin
				next_r.busy = 1'b0;
				next_r.stackCnt = '0;
				next_r.bitIdx = '0;
			end
			else
			begin
				for (int a = 0; a < N_AXIS; a++)
				begin
					next_r.plusP[a] = active[a] & r.shift[a][0][0];
					next_r.minusP[a] = active[a] & r.shift[a][1][0];
					for (int d = 0; d < 2; d++)
					begin
						next_r.shift[a][d] = {1'b0, r.shift[a][d][15:1]};
					end
				end
				next_r.rangeSel = clvRange(r.mode[MODE_CLV_HI:MODE_CLV_LO],
					next_r.plusP | next_r.minusP);
				next_r.bitIdx = 4'(r.bitIdx + 4'h1);
				if (r.bitIdx == LAST_BIT)
				begin
					next_r.shift = r.q1;
					next_r.q1 = r.q2;
					next_r.stackCnt = 2'(r.stackCnt - 2'h1);
					intSet = r.stackCnt == 2'h2 && r.mode[MODE_INT_EN];
					if (r.stackCnt == 2'h1)
					begin
						next_r.busy = 1'b0;
					end
				end
			end
		end

		if (stopReq)
		begin
			next_r.busy = 1'b0;
		end

		if (isCmd)
		begin
			case (bus.busWdata)
				CMD_START2, CMD_START3:
				begin
					next_r.busy = r.stackCnt != 2'h0;
					next_r.three = bus.busWdata == CMD_START3;
				end
				CMD_WR_EN:
				begin
					next_r.wrEn = 1'b1;
				end
				CMD_WR_DIS:
				begin
					next_r.wrEn = 1'b0;
				end
				CMD_CLEAR:
				begin
					next_r.stackCnt = '0;
					next_r.bitIdx = '0;
				end
				CMD_INT_CLR:
				begin
					intClr = 1'b1;
				end
				CMD_PUSH:
				begin
					intClr = 1'b1;
					// Slot follows the count after any advance this cycle.
					case (next_r.stackCnt)
						2'h0:
						begin
							next_r.shift = r.hold;
						end
						2'h1:
						begin
							next_r.q1 = r.hold;
						end
						2'h2:
						begin
							next_r.q2 = r.hold;
						end
						default:
						begin
							next_r.q2 = r.q2;
						end
					endcase
					if (next_r.stackCnt != CNT_FULL)
					begin
						next_r.stackCnt = 2'(next_r.stackCnt + 2'h1);
					end
				end
				default:
				begin
					intClr = 1'b0;
				end
			endcase
		end
		else if (bus.busWr && r.wrEn && bus.busAddr >= ADDR_PAT_FIRST)
		begin
			next_r.hold[off[2:1]][off[0]] = bus.busWdata;
		end
		else if (bus.busWr && bus.busAddr == ADDR_MODE)
		begin
			next_r.mode = bus.busWdata;
		end

		if (r.busy && !next_r.busy)
		begin
			intClr = 1'b1;
		end
		// A new refill event outweighs a clear in the same cycle.
		next_r.intPend = (r.intPend & ~intClr) | intSet;

		if (srst)
		begin
			next_r = '0;
			next_r.mode = MODE_RESET;
		end
	end

	always_ff @(posedge ref_clk)
	begin
		r <= next_r;
	end

	assign bus.busRdata = r.rdata;
	assign bus.intOutN = 1'b0;
	assign bus.intOutNOe = r.intPend;
	assign plusPulse = r.plusP;
	assign minusPulse = r.minusP;
	assign rangeSel = r.rangeSel;
	assign driveBusy = r.busy;
endmodule

/* File: bpi_pkg.sv */
package bpi_pkg;
	localparam int W_DATA = 16;
	localparam int W_ADDR = 3;
	localparam int N_AXIS = 3;
	localparam int N_SLOT = 4;
	localparam int N_OP = 7;

	// Device bus addresses.
	localparam logic [2:0] ADDR_CMD = 3'h0;
	localparam logic [2:0] ADDR_STATUS = 3'h0;
	localparam logic [2:0] ADDR_PAT_FIRST = 3'h2;
	localparam logic [2:0] ADDR_MODE = 3'h5;

	// Command codes written to the command word.
	localparam logic [15:0] CMD_START2 = 16'h0034;
	localparam logic [15:0] CMD_START3 = 16'h0035;
	localparam logic [15:0] CMD_WR_EN = 16'h0036;
	localparam logic [15:0] CMD_WR_DIS = 16'h0037;
	localparam logic [15:0] CMD_PUSH = 16'h0038;
	localparam logic [15:0] CMD_CLEAR = 16'h0039;
	localparam logic [15:0] CMD_INT_CLR = 16'h003D;

	// Mode-control word fields.
	localparam int MODE_INT_EN = 15;
	localparam int MODE_CLV_HI = 9;
	localparam int MODE_CLV_LO = 8;
	localparam logic [1:0] CLV_TWO = 2'h1;
	localparam logic [1:0] CLV_THREE = 2'h3;
	localparam logic [15:0] MODE_RESET = 16'h0000;

	// Main status word fields.
	localparam int STAT_CNT_HI = 14;
	localparam int STAT_CNT_LO = 13;
	localparam int STAT_BUSY = 8;
	localparam logic [1:0] CNT_FULL = 2'h3;
	localparam logic [3:0] LAST_BIT = 4'hF;

	// Range selection codes.
	localparam logic [1:0] RANGE_MAIN = 2'h0;
	localparam logic [1:0] RANGE_SECOND = 2'h1;
	localparam logic [1:0] RANGE_THIRD = 2'h2;

	// Host controller registers.
	localparam logic [2:0] HREG_CTRL = 3'h0;
	localparam logic [2:0] HREG_MODE = 3'h1;
	localparam logic [2:0] HREG_DEV = 3'h2;
	localparam logic [2:0] HREG_PAT_FIRST = 3'h4;
	localparam int HCTRL_BUSY = 0;
	localparam int HCTRL_PEND = 1;
	localparam int HCTRL_INT = 2;

	// Host operation bits, served lowest first.
	localparam int OP_MODE = 0;
	localparam int OP_CLEAR = 1;
	localparam int OP_WR_EN = 2;
	localparam int OP_PUSH = 3;
	localparam int OP_START = 4;
	localparam int OP_WR_DIS = 5;
	localparam int OP_INT_CLR = 6;
	localparam logic [2:0] PAT_LAST = 3'h4;
endpackage

/* File: bpi_if.sv */
`timescale 1ns/100ps
interface bpi_if;
	import bpi_pkg::*;
	logic [W_ADDR-1:0] busAddr;
	logic [W_DATA-1:0] busWdata;
	logic              busWr;
	logic              busRd;
	logic [W_DATA-1:0] busRdata;
	logic              intOutN;
	logic              intOutNOe;
	logic              intLineN;

	// Open-drain line with its pull-up folded in.
	assign intLineN = intOutNOe ? intOutN : 1'b1;

	modport device (
		input  busAddr,
		input  busWdata,
		input  busWr,
		input  busRd,
		output busRdata,
		output intOutN,
		output intOutNOe
	);
	modport host (
		output busAddr,
		output busWdata,
		output busWr,
		output busRd,
		input  busRdata,
		input  intLineN
	);
endinterface

/* File: bpi_host.sv */
`timescale 1ns/100ps
module bpi_host
	import bpi_pkg::*;
(
	input  wire logic                  ref_clk,
	input  wire logic                  srst,
	bpi_if.host                        bus,
	input  wire logic [bpi_pkg::W_ADDR-1:0] hAddr,
	input  wire logic [bpi_pkg::W_DATA-1:0] hWdata,
	input  wire logic                  hWr,
	input  wire logic                  hRd,
	output logic [bpi_pkg::W_DATA-1:0] hRdata
);
	import bpi_pkg::*;

	typedef enum logic [1:0] {
		ST_IDLE  = 2'b00,
		ST_WAIT  = 2'b01,
		ST_CHECK = 2'b10,
		ST_PAT   = 2'b11
	} bpi_hst_e;

	typedef struct packed {
		bpi_hst_e               state;
		logic [N_OP-1:0]        pend;
		logic [2:0]             idx;
		logic [W_DATA-1:0]      modeWord;
		logic [N_SLOT-1:0][W_DATA-1:0] stage;
		logic [W_DATA-1:0]      devStat;
		logic                   rdWas;
		logic [W_ADDR-1:0]      addr;
		logic [W_DATA-1:0]      wdata;
		logic                   wr;
		logic                   rd;
		logic [W_DATA-1:0]      hrdata;
	} bpi_hst_s;

	bpi_hst_s r;
	bpi_hst_s next_r;

	function automatic logic [15:0] opCode(input logic [2:0] op);
		case (op)
			3'(OP_CLEAR):   opCode = CMD_CLEAR;
			3'(OP_WR_EN):   opCode = CMD_WR_EN;
			3'(OP_START):   opCode = CMD_START2;
			3'(OP_WR_DIS):  opCode = CMD_WR_DIS;
			3'(OP_INT_CLR): opCode = CMD_INT_CLR;
			default:        opCode = CMD_PUSH;
		endcase
	endfunction

	always_comb
	begin
		logic [2:0]      op;
		logic [N_OP-1:0] done;
		op = '0;
		done = '0;
		next_r = r;
		next_r.wr = 1'b0;
		next_r.rd = 1'b0;
		next_r.hrdata = '0;
		next_r.rdWas = r.rd;
		if (r.rdWas)
		begin
			next_r.devStat = bus.busRdata;
		end

		for (int i = N_OP - 1; i >= 0; i--)
		begin
			if (r.pend[i])
			begin
				op = 3'(i);
			end
		end

		case (r.state)
			ST_IDLE:
			begin
				if (r.pend != '0)
				begin
					done[op] = 1'b1;
					if (op == 3'(OP_PUSH))
					begin
						next_r.rd = 1'b1;
						next_r.addr = ADDR_STATUS;
						next_r.state = ST_WAIT;
					end
					else
					begin
						next_r.wr = 1'b1;
						// Mode is written while pattern writes are off.
						next_r.addr = op == 3'(OP_MODE) ? ADDR_MODE : ADDR_CMD;
						next_r.wdata = op == 3'(OP_MODE) ? r.modeWord : opCode(op);
					end
				end
				else if (!r.rd && !r.rdWas)
				begin
					next_r.rd = 1'b1;
					next_r.addr = ADDR_STATUS;
				end
			end
			ST_WAIT:
			begin
				next_r.state = ST_CHECK;
			end
			ST_CHECK:
			begin
				if (bus.busRdata[STAT_CNT_HI:STAT_CNT_LO] == CNT_FULL)
				begin
					next_r.rd = 1'b1;
					next_r.state = ST_WAIT;
				end
				else
				begin
					next_r.idx = '0;
					next_r.state = ST_PAT;
				end
			end
			ST_PAT:
			begin
				next_r.wr = 1'b1;
				next_r.idx = 3'(r.idx + 3'h1);
				if (r.idx == PAT_LAST)
				begin
					next_r.addr = ADDR_CMD;
					next_r.wdata = CMD_PUSH;
					next_r.state = ST_IDLE;
				end
				else
				begin
					next_r.addr = 3'(ADDR_PAT_FIRST + r.idx);
					next_r.wdata = r.stage[r.idx[1:0]];
				end
			end
			default:
			begin
				next_r.state = ST_IDLE;
			end
		endcase

		next_r.pend = r.pend & ~done;
		if (hWr)
		begin
			if (hAddr == HREG_CTRL)
			begin
				next_r.pend[N_OP-1:1] = next_r.pend[N_OP-1:1] | hWdata[N_OP-2:0];
			end
			else if (hAddr == HREG_MODE)
			begin
				next_r.modeWord = hWdata;
				next_r.pend[OP_MODE] = 1'b1;
			end
			else if (hAddr >= HREG_PAT_FIRST)
			begin
				next_r.stage[hAddr[1:0]] = hWdata;
			end
		end
		if (hRd)
		begin
			case (hAddr)
				HREG_CTRL:
				begin
					next_r.hrdata[HCTRL_BUSY] = r.state != ST_IDLE;
					next_r.hrdata[HCTRL_PEND] = r.pend != '0;
					next_r.hrdata[HCTRL_INT] = !bus.intLineN;
				end
				HREG_MODE:
				begin
					next_r.hrdata = r.modeWord;
				end
				HREG_DEV:
				begin
					next_r.hrdata = r.devStat;
				end
				default:
				begin
					next_r.hrdata = hAddr >= HREG_PAT_FIRST ?
						r.stage[hAddr[1:0]] : '0;
				end
			endcase
		end

		if (srst)
		begin
			next_r = '0;
			next_r.state = ST_IDLE;
		end
	end

	always_ff @(posedge ref_clk)
	begin
		r <= next_r;
	end

	assign bus.busAddr = r.addr;
	assign bus.busWdata = r.wdata;
	assign bus.busWr = r.wr;
	assign bus.busRd = r.rd;
	assign hRdata = r.hrdata;
endmodule

/* File: bpi_chk.sv */
`timescale 1ns/100ps
module bpi_chk
	import bpi_pkg::*;
(
	input wire logic                           ref_clk,
	input wire logic                           srst,
	input wire logic [bpi_pkg::W_ADDR-1:0] busAddr,
	input wire logic [bpi_pkg::W_DATA-1:0] busWdata,
	input wire logic                           busWr,
	input wire logic                           busRd,
	input wire logic [bpi_pkg::W_DATA-1:0] busRdata,
	input wire logic                           intOutN,
	input wire logic                           intOutNOe,
	input wire logic                           intLineN
);
	logic [1:0] lastCnt;
	logic       statRd;
	wire        cmdWr = busWr && busAddr == ADDR_CMD;

	default clocking @(posedge ref_clk); endclocking
	default disable iff (srst);

	// The last stack count the host saw; a push must rest on a fresh poll.
	always_ff @(posedge ref_clk)
	begin
		statRd <= !srst && busRd && busAddr == ADDR_STATUS;
		if (srst)
			lastCnt <= 2'h0;
		else if (statRd)
			lastCnt <= busRdata[STAT_CNT_HI:STAT_CNT_LO];
	end

	sequence s_words;
		busWr && busAddr == 3'h3 ##1 busWr && busAddr == 3'h4
			##1 busWr && busAddr == 3'h5;
	endsequence

	a_oe_drives_low: assert property (intOutNOe |-> !intOutN)
		else $error("interrupt drive value not low");
	a_line_follows: assert property (intLineN == !intOutNOe)
		else $error("interrupt line level wrong");
	a_push_clears: assert property (cmdWr && busWdata == CMD_PUSH |=> !intOutNOe)
		else $error("push left interrupt pending");
	a_intclr_clears: assert property (cmdWr && busWdata == CMD_INT_CLR |=> !intOutNOe)
		else $error("interrupt clear ignored");
	a_push_burst: assert property (busWr && busAddr == ADDR_PAT_FIRST |=>
		s_words ##1 cmdWr && busWdata == CMD_PUSH)
		else $error("pattern words not pushed as a group");
	a_full_wait: assert property (cmdWr && busWdata == CMD_PUSH |-> lastCnt != CNT_FULL)
		else $error("push issued while stack full");
	a_start_two: assert property (cmdWr |-> busWdata != CMD_START3)
		else $error("host issued three-axis start");
	a_rdata_slot: assert property (!$past(busRd) |-> busRdata == '0)
		else $error("read data outside its slot");
endmodule

/* File: bit_pattern_interp_clv_tb.sv */
`timescale 1ns/100ps
module bit_pattern_interp_clv_tb;
	import bpi_pkg::*;
	logic        ref_clk = 1'b0;
	logic        srst = 1'b1;
	logic [2:0]  hAddr = 3'h0;
	logic [15:0] hWdata = 16'h0000;
	logic        hWr = 1'b0;
	logic        hRd = 1'b0;
	logic [15:0] hRdata;
	logic        basicPulse = 1'b0;
	logic        stopReq = 1'b0;
	logic [2:0]  plusPulse;
	logic [2:0]  minusPulse;
	logic [1:0]  rangeSel;
	logic        driveBusy;
	logic [15:0] pat [4][4];
	logic [15:0] v;
	int          n_fail = 0;
	int          total_checks = 0;

	bpi_if busIf();
	bpi_device bpi_device_i(.ref_clk(ref_clk), .srst(srst), .bus(busIf),
		.basicPulse(basicPulse), .stopReq(stopReq), .plusPulse(plusPulse),
		.minusPulse(minusPulse), .rangeSel(rangeSel), .driveBusy(driveBusy));
	bpi_host bpi_host_i(.ref_clk(ref_clk), .srst(srst), .bus(busIf),
		.hAddr(hAddr), .hWdata(hWdata), .hWr(hWr), .hRd(hRd), .hRdata(hRdata));
	bpi_chk bpi_chk_i(.ref_clk(ref_clk), .srst(srst), .busAddr(busIf.busAddr),
		.busWdata(busIf.busWdata), .busWr(busIf.busWr), .busRd(busIf.busRd),
		.busRdata(busIf.busRdata), .intOutN(busIf.intOutN),
		.intOutNOe(busIf.intOutNOe), .intLineN(busIf.intLineN));

	always #50 ref_clk = ~ref_clk;

	task stop_test;
		if (n_fail == 0 && total_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	task check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			n_fail++;
			$display("[ERR] %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task hwrite(input logic [2:0] a, input logic [15:0] d);
		@(posedge ref_clk);
		hAddr <= a;
		hWdata <= d;
		hWr <= 1'b1;
		@(posedge ref_clk);
		hWr <= 1'b0;
	endtask

	task hread(input logic [2:0] a);
		@(posedge ref_clk);
		hAddr <= a;
		hRd <= 1'b1;
		@(posedge ref_clk);
		hRd <= 1'b0;
		@(negedge ref_clk);
		v = hRdata;
	endtask

	// Queued operations finish at the host's own pace, so poll with a bound.
	task op(input logic [15:0] bits);
		int i;
		hwrite(HREG_CTRL, bits);
		for (i = 0; i < 200; i++)
		begin
			hread(HREG_CTRL);
			if (v[1:0] == 2'h0)
				break;
		end
		if (i == 200)
		begin
			n_fail++;
			stop_test();
		end
		repeat (6) @(posedge ref_clk);
	endtask

	task stage(input int k);
		for (int j = 0; j < 4; j++)
			hwrite(HREG_PAT_FIRST + 3'(j), pat[k][j]);
	endtask

	task dev(input logic [1:0] cnt, input logic busy);
		hread(HREG_DEV);
		check("count", 16'(v[STAT_CNT_HI:STAT_CNT_LO]), 16'(cnt));
		check("busy", 16'(v[STAT_BUSY]), 16'(busy));
		check("driveBusy", 16'(driveBusy), 16'(busy));
	endtask

	function automatic logic [5:0] ex(input int k, input int j);
		return {1'b0, pat[k][2][j], pat[k][0][j], 1'b0, pat[k][3][j], pat[k][1][j]};
	endfunction

	// The pulse is looked for over two cycles, since it stands for one.
	task step(input logic [5:0] e);
		logic [5:0] s;
		s = 6'h00;
		@(posedge ref_clk);
		basicPulse <= 1'b1;
		@(posedge ref_clk);
		basicPulse <= 1'b0;
		repeat (2)
		begin
			@(negedge ref_clk);
			s = s | {plusPulse, minusPulse};
		end
		check("pulses", 16'(s), 16'(e));
		if (e != 6'h00)
			check("range", 16'(rangeSel), ((e[4] | e[1]) && (e[3] | e[0])) ?
				16'(RANGE_SECOND) : 16'(RANGE_MAIN));
	endtask

	initial
	begin
		for (int k = 0; k < 3; k++)
		begin
			pat[k][0] = 16'h5555 ^ {4{4'(k)}};
			pat[k][1] = ~pat[k][0] & 16'h0F00;
			pat[k][2] = 16'h3333 ^ {4{4'(k)}};
			pat[k][3] = ~pat[k][2] & 16'h00F0;
		end
		pat[3] = '{16'h0020, 16'h0020, 16'h0000, 16'h0000};
		repeat (20) @(posedge ref_clk);
		srst <= 1'b0;
		hread(HREG_CTRL);
		check("ctrl", v, 16'h0000);
		check("line", 16'(busIf.intLineN), 16'h0001);
		hwrite(HREG_MODE, 16'h8100);
		stage(0);
		op(16'h0007);
		dev(2'h1, 1'b0);
		op(16'h0001);
		dev(2'h0, 1'b0);
		op(16'h0008);
		dev(2'h0, 1'b0);
		for (int k = 0; k < 3; k++)
		begin
			stage(k);
			op(16'h0004);
		end
		dev(2'h3, 1'b0);
		op(16'h0008);
		dev(2'h3, 1'b1);
		for (int i = 0; i < 32; i++)
			step(ex(i / 16, i % 16));
		check("int", 16'(busIf.intLineN), 16'h0000);
		op(16'h0020);
		check("int", 16'(busIf.intLineN), 16'h0001);
		// Mode may only be rewritten while pattern writes are off.
		op(16'h0010);
		hwrite(HREG_MODE, 16'h8300);
		op(16'h0002);
		for (int k = 1; k < 4; k += 2)
		begin
			stage(k);
			op(16'h0004);
			check("int", 16'(busIf.intLineN), 16'h0001);
			dev(2'h2, 1'b1);
			for (int i = 0; i < 16; i++)
				step(ex(2 - k / 2, i));
			check("int", 16'(busIf.intLineN), 16'h0000);
		end
		for (int i = 0; i < 5; i++)
			step(ex(3, i));
		step(6'h00);
		check("int", 16'(busIf.intLineN), 16'h0001);
		repeat (6) @(posedge ref_clk);
		dev(2'h0, 1'b0);
		op(16'h000C);
		dev(2'h1, 1'b1);
		@(posedge ref_clk);
		stopReq <= 1'b1;
		@(posedge ref_clk);
		stopReq <= 1'b0;
		@(negedge ref_clk);
		check("stop", 16'(driveBusy), 16'h0000);
		stop_test();
	end
endmodule
